// *** reset_cause_defines.vh ***
// Purpose: Constants for the reset cause and initialisation block
// Assumes: Included by reset_cause_and_init_logic.v only
// Notes:   Register indices and field positions of the plain register port
`ifndef RESET_CAUSE_DEFINES_VH
`define RESET_CAUSE_DEFINES_VH

// Register addresses (word index on the plain port)
`define ADDR_CTRL          4'h0
`define ADDR_VSEL          4'h1
`define ADDR_WDEN          4'h2
`define ADDR_STATUS        4'h3
`define ADDR_IRQ_STAT      4'h4
`define ADDR_IRQ_MASK      4'h5

// Control register fields
`define CTRL_SYSON_BIT     7
`define CTRL_FSEL_HI       5
`define CTRL_FSEL_LO       4
`define CTRL_LVR_BIT       2
`define CTRL_VSEL_BIT      1
`define CTRL_WDEN_BIT      0
`define CTRL_WMASK         8'hB7

// Status register fields
`define STAT_TO_BIT        0
`define STAT_PD_BIT        1

// Reset values and legal codes
`define VSEL_RESET         8'h55
`define WDEN_RESET         5'h0A
`define WDEN_OK_A          5'h0A
`define WDEN_OK_B          5'h15
`define VSEL_OK_A          8'h55
`define VSEL_OK_B          8'h33
`define VSEL_OK_C          8'h99
`define VSEL_OK_D          8'hAA

// Interrupt event bits
`define EV_LVR             0
`define EV_VSEL            1
`define EV_WDEN            2
`define EV_WDT             3
`define EV_WIDTH           4

// Start-up delay and debounce counts, in system clocks / slow clocks
`define SST_FAST_CYC       4'hF
`define SST_SLOW_CYC       4'h1
`define DEBOUNCE_SLOW_CYC  2'h2
`define CNT_ZERO           4'h0

`endif

// *** reset_cause_and_init_logic.v ***
// Purpose: Records reset causes and drives reset-state controls to the core
// Assumes: Single clock mclk_in; slow-oscillator tick arrives as a pin
// Notes:   Reset request pulses last one clock per event; power-on reset holds them high
//
// Function
// - Low-voltage event sets sticky flag; software clears
// - Illegal voltage select sets sticky flag
// - Control bits 6 and 3 read zero
// - Power-on clears flags, select and idle bits
// - Run-mode watchdog timeout gives full reset
// - Sleep timeout clears only counter and stack
// - Wake start-up delay by oscillator choice
// - Low-voltage reset keeps timeout and power-down
// - Run timeout sets timeout, keeps power-down
// - Sleep timeout sets timeout and power-down
// - Power-on zeroes counter, disables interrupts
// - Power-on clears and restarts watchdog
// - Power-on switches timer off
// - Power-on makes pins inputs, analogue channels
// - Power-on stack pointer at top
// - Illegal watchdog enable sets sticky flag
// - Illegal select resets after slow-clock debounce
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "reset_cause_defines.vh"

module reset_cause_and_init_logic
#(
    parameter SST_FAST = 4'hF,
    parameter SST_SLOW = 4'h1
)
(
    // Clock, reset, enable
    input  wire        mclk_in,
    input  wire        resetn_in,
    input  wire        ce_in,
    // Register port
    input  wire [3:0]  addr_in,
    input  wire [7:0]  wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [7:0]  rdata_out,
    // Events from analogue and core (pins, synchronised here)
    input  wire        low_voltage_in,
    input  wire        wdt_timeout_in,
    input  wire        slow_tick_in,
    // Core state (same clock)
    input  wire        sleep_mode_in,
    // Reset controls to core
    output reg         full_reset_out,
    output reg         pc_sp_clear_out,
    output reg         wdt_clear_out,
    output reg         core_hold_out,
    output reg         irq_disable_out,
    output reg         timer_off_out,
    output reg         pins_input_out,
    output reg         analogue_channel_pins_out,
    output reg         sp_top_out,
    // Interrupt
    output reg         irq_out
);

    // ****************************************
    // Reset synchroniser
    // ****************************************
    reg rst_s1_r;
    reg rst_s2_r;
    wire rst_n;

    // Two-stage release of the external reset
    always @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [2:0] pin_s1_r;
    reg [2:0] pin_s2_r;
    reg       tick_d_r;
    wire      lv_sync;
    wire      wdt_sync;
    wire      tick_rise;

    // Only the second stage is read by logic
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
            tick_d_r <= 1'b0;
        end
        else if (ce_in)
        begin
            pin_s1_r <= {slow_tick_in, wdt_timeout_in, low_voltage_in};
            pin_s2_r <= pin_s1_r;
            tick_d_r <= pin_s2_r[2];
        end
    end
    assign lv_sync   = pin_s2_r[0];
    assign wdt_sync  = pin_s2_r[1];
    assign tick_rise = pin_s2_r[2] & ~tick_d_r;

    // ****************************************
    // Registers
    // ****************************************
    reg                  syson_r;
    reg  [1:0]           fsel_r;
    reg                  lvr_flag_r;
    reg                  vsel_flag_r;
    reg                  wden_flag_r;
    reg  [7:0]           vsel_r;
    reg  [4:0]           wden_r;
    reg                  to_r;
    reg                  pd_r;
    reg  [`EV_WIDTH-1:0] irq_stat_r;
    reg  [`EV_WIDTH-1:0] irq_mask_r;
    reg  [1:0]           deb_cnt_r;
    reg  [3:0]           sst_cnt_r;
    reg                  lv_d_r;
    reg                  wdt_d_r;
    wire                 lv_rise;
    wire                 wdt_rise;
    wire                 vsel_bad;
    wire                 wden_bad;
    wire                 deb_done;
    wire [`EV_WIDTH-1:0] ev;
    wire                 wr_ctrl;

    // Legal voltage select codes
    function vsel_legal;
        input [7:0] v;
        begin
            vsel_legal = (v == `VSEL_OK_A) || (v == `VSEL_OK_B) ||
                         (v == `VSEL_OK_C) || (v == `VSEL_OK_D);
        end
    endfunction

    assign lv_rise  = lv_sync & ~lv_d_r;
    assign wdt_rise = wdt_sync & ~wdt_d_r;
    assign vsel_bad = ~vsel_legal(vsel_r);
    assign wden_bad = (wden_r != `WDEN_OK_A) && (wden_r != `WDEN_OK_B);
    assign deb_done = (vsel_bad | wden_bad) && (deb_cnt_r == `DEBOUNCE_SLOW_CYC) && tick_rise;
    assign ev       = {wdt_rise, deb_done & wden_bad, deb_done & vsel_bad, lv_rise};
    assign wr_ctrl  = wr_in && (addr_in == `ADDR_CTRL);

    // Register file, flags and reset sequencing
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syson_r     <= 1'b0;
            fsel_r      <= 2'h0;
            lvr_flag_r  <= 1'b0;
            vsel_flag_r <= 1'b0;
            wden_flag_r <= 1'b0;
            vsel_r      <= `VSEL_RESET;
            wden_r      <= `WDEN_RESET;
            to_r        <= 1'b0;
            pd_r        <= 1'b0;
            irq_stat_r  <= {`EV_WIDTH{1'b0}};
            irq_mask_r  <= {`EV_WIDTH{1'b0}};
            deb_cnt_r   <= 2'h0;
            sst_cnt_r   <= `CNT_ZERO;
            lv_d_r      <= 1'b0;
            wdt_d_r     <= 1'b0;
        end
        else if (ce_in)
        begin
            lv_d_r  <= lv_sync;
            wdt_d_r <= wdt_sync;
            // Control writes first, so hardware sets below win
            if (wr_ctrl)
            begin
                syson_r     <= wdata_in[`CTRL_SYSON_BIT];
                fsel_r      <= wdata_in[`CTRL_FSEL_HI:`CTRL_FSEL_LO];
                lvr_flag_r  <= wdata_in[`CTRL_LVR_BIT];
                vsel_flag_r <= wdata_in[`CTRL_VSEL_BIT];
                wden_flag_r <= wdata_in[`CTRL_WDEN_BIT];
            end
            if (wr_in && (addr_in == `ADDR_VSEL))
                vsel_r <= wdata_in;
            if (wr_in && (addr_in == `ADDR_WDEN))
                wden_r <= wdata_in[4:0];
            if (wr_in && (addr_in == `ADDR_IRQ_MASK))
                irq_mask_r <= wdata_in[`EV_WIDTH-1:0];
            // Debounce counter advances on slow ticks while a code is bad
            if (!(vsel_bad | wden_bad) || deb_done)
                deb_cnt_r <= 2'h0;
            else if (tick_rise)
                deb_cnt_r <= deb_cnt_r + 2'h1;
            if (lv_rise)
                lvr_flag_r <= 1'b1;
            // sticky select flag, then reload default
            if (ev[`EV_VSEL])
            begin
                vsel_flag_r <= 1'b1;
                vsel_r      <= `VSEL_RESET;
            end
            if (ev[`EV_WDEN])
            begin
                wden_flag_r <= 1'b1;
                wden_r      <= `WDEN_RESET;
            end
            if (wdt_rise)
            begin
                to_r <= 1'b1;
                if (sleep_mode_in)
                    pd_r <= 1'b1;
            end
            if (wdt_rise && sleep_mode_in)
                sst_cnt_r <= (fsel_r == 2'h0) ? SST_SLOW : SST_FAST;
            else if (sst_cnt_r != `CNT_ZERO)
                sst_cnt_r <= sst_cnt_r - 4'h1;
            // Read clears status; new events win over the clear
            if (rd_in && (addr_in == `ADDR_IRQ_STAT))
                irq_stat_r <= ev;
            else
                irq_stat_r <= irq_stat_r | ev;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    reg [7:0] rdata_nxt;
    wire      any_full;

    assign any_full = lv_rise | deb_done | (wdt_rise & ~sleep_mode_in);

    // Read mux
    always @*
    begin
        rdata_nxt = 8'h00;
        case (addr_in)
            // bits 6 and 3 read zero
            `ADDR_CTRL:     rdata_nxt = {syson_r, 1'b0, fsel_r, 1'b0,
                                         lvr_flag_r, vsel_flag_r, wden_flag_r} & `CTRL_WMASK;
            `ADDR_VSEL:     rdata_nxt = vsel_r;
            `ADDR_WDEN:     rdata_nxt = {3'h0, wden_r};
            `ADDR_STATUS:   rdata_nxt = {6'h00, pd_r, to_r};
            `ADDR_IRQ_STAT: rdata_nxt = {4'h0, irq_stat_r};
            `ADDR_IRQ_MASK: rdata_nxt = {4'h0, irq_mask_r};
            default:        rdata_nxt = 8'h00;
        endcase
    end

    // Registered outputs; full reset also re-applies power-on conditions
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_out                 <= 8'h00;
            full_reset_out            <= 1'b1;
            pc_sp_clear_out           <= 1'b1;
            wdt_clear_out             <= 1'b1;
            core_hold_out             <= 1'b1;
            irq_disable_out           <= 1'b1;
            timer_off_out             <= 1'b1;
            pins_input_out            <= 1'b1;
            analogue_channel_pins_out <= 1'b1;
            sp_top_out                <= 1'b1;
            irq_out                   <= 1'b0;
        end
        else if (ce_in)
        begin
            rdata_out       <= rd_in ? rdata_nxt : 8'h00;
            full_reset_out  <= any_full;
            // sleep timeout clears counter and stack only
            pc_sp_clear_out <= any_full | (wdt_rise & sleep_mode_in);
            wdt_clear_out   <= any_full;
            core_hold_out   <= any_full | (wdt_rise & sleep_mode_in) |
                               (sst_cnt_r > 4'h1);
            irq_disable_out <= any_full;
            timer_off_out   <= any_full;
            pins_input_out            <= any_full;
            analogue_channel_pins_out <= any_full;
            sp_top_out      <= any_full;
            irq_out         <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule
`default_nettype wire

// *** reset_cause_checker.sv ***
// Purpose: Port assertions for the reset cause block
// Assumes: Bound to every instance of the top module
// Notes:   Event bounds allow for the two-flop pin sync
`timescale 1ns/100ps
`default_nettype none
module reset_cause_checker
(
    // Clock, reset, bus
    input wire       mclk_in, resetn_in, ce_in, wr_in, rd_in,
    input wire [3:0] addr_in,
    input wire [7:0] wdata_in, rdata_out,
    // Events, core, controls
    input wire       low_voltage_in, wdt_timeout_in, slow_tick_in,
    input wire       sleep_mode_in, full_reset_out, pc_sp_clear_out,
    input wire       wdt_clear_out, core_hold_out, irq_disable_out,
    input wire       timer_off_out, pins_input_out, sp_top_out,
    input wire       analogue_channel_pins_out, irq_out
);
// ****
// Properties
// ****
default clocking @(posedge mclk_in); endclocking
default disable iff (!resetn_in);

// Unused control bits never leak
ctrl_gaps_zero_a: assert property (rd_in && ce_in && addr_in == 4'h0 |=>
    !rdata_out[6] && !rdata_out[3]) else $error("control gap bit set");
// Read data only in the answer cycle
rdata_idle_a: assert property (!rd_in && ce_in |=> rdata_out == 8'h00)
    else $error("read data outside answer cycle");
// Full reset carries every init control; this check leaves out pc/sp clear and core hold
full_set_a: assert property (full_reset_out |-> wdt_clear_out &&
    irq_disable_out && timer_off_out && pins_input_out && analogue_channel_pins_out
    && sp_top_out) else $error("init control missing in full reset");
run_wdt_full_a: assert property ($rose(wdt_timeout_in) && !sleep_mode_in |->
    ##[1:6] full_reset_out) else $error("run timeout without full reset");
lvr_full_a: assert property ($rose(low_voltage_in) |-> ##[1:6] full_reset_out)
    else $error("low voltage without full reset");
sleep_wdt_pcsp_a: assert property ($rose(wdt_timeout_in) && sleep_mode_in |->
    ##[1:6] (pc_sp_clear_out && !full_reset_out)) else $error("sleep timeout wrong reset");
// Partial reset must leave pin, timer and interrupt controls alone
sleep_keep_a: assert property (pc_sp_clear_out && !full_reset_out |->
    !pins_input_out && !timer_off_out && !irq_disable_out) else $error("sleep reset too wide");
wake_hold_end_a: assert property ($rose(pc_sp_clear_out) |-> ##[1:20] !core_hold_out)
    else $error("start-up hold too long");
endmodule
bind reset_cause_and_init_logic reset_cause_checker chk_u (.*);
`default_nettype wire

// *** core_sleep_model.sv ***
// Purpose: Core side: sleep level and free-running slow oscillator
// Assumes: Same clock as the block
// Notes:   Slow tick period is four system clocks to keep runs short
`timescale 1ns/100ps
`default_nettype none
module core_sleep_model
(
    input  wire logic mclk_in, resetn_in, sleep_req_in,
    output var logic  sleep_mode_out,
    output wire logic slow_tick_out
);
logic [1:0] div_r;
// Sleep follows the firmware request one clock later
always @(posedge mclk_in or negedge resetn_in)
begin
    if (!resetn_in)
    begin
        div_r <= 2'h0;
        sleep_mode_out <= 1'b0;
    end
    else
    begin
        div_r <= div_r + 2'h1;
        sleep_mode_out <= sleep_req_in;
    end
end
assign slow_tick_out = div_r[1];
endmodule
`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the reset cause block
// Assumes: Core model supplies sleep level and slow tick
// Notes:   Clock enable held high; freeze path left untested
`timescale 1ns/100ps
`default_nettype none
module tb;
logic       mclk_in = 1'b0, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
logic       low_voltage_in = 1'b0, wdt_timeout_in = 1'b0, sleep_req = 1'b0;
logic [3:0] addr_in = 4'h0;
logic [7:0] wdata_in = 8'h00;
wire        sleep_mode, slow_tick, full_rst, pcsp, wdtc, hold, irqd, tmr, pins, ana, spt, irq;
wire  [7:0] rdata_out;
int         error_cnt = 0, checks_done = 0, n, m;
always #50 mclk_in = ~mclk_in;
core_sleep_model core_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .sleep_req_in(sleep_req),
    .sleep_mode_out(sleep_mode), .slow_tick_out(slow_tick));
reset_cause_and_init_logic dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(1'b1),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .low_voltage_in(low_voltage_in), .wdt_timeout_in(wdt_timeout_in),
    .slow_tick_in(slow_tick), .sleep_mode_in(sleep_mode), .full_reset_out(full_rst),
    .pc_sp_clear_out(pcsp), .wdt_clear_out(wdtc), .core_hold_out(hold),
    .irq_disable_out(irqd), .timer_off_out(tmr), .pins_input_out(pins),
    .analogue_channel_pins_out(ana), .sp_top_out(spt), .irq_out(irq));
// ****
// Tasks
// ****
task finish_test;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
        error_cnt++;
        $display("[ERR] %s exp %h got %h", s, e, g);
    end
endtask
task wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    // Let one edge pass so a following call never re-drives the strobe in this step
    @(posedge mclk_in);
endtask
// Data stands only in the cycle after the strobe
task rd(input logic [3:0] a, input logic [7:0] e, input string s);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 chk(s, e, rdata_out);
    @(posedge mclk_in);
endtask
// Bounded wait for full reset (0) or pc/sp clear (1), then count hold cycles
task wt(input bit s);
    n = 0;
    m = 0;
    do begin @(posedge mclk_in); #1 n++; end while (!(s ? pcsp : full_rst) && n < 200);
    if (n >= 200)
    begin
        error_cnt++;
        finish_test;
    end
    repeat (25) begin @(posedge mclk_in); #1 m += hold; end
    @(posedge mclk_in);
endtask
// Sleep-mode watchdog time-out with oscillator choice in control
task nap(input logic [7:0] c);
    wr(4'h0, c);
    sleep_req <= 1'b1;
    repeat (3) @(posedge mclk_in);
    wdt_timeout_in <= 1'b1;
    wt(1'b1);
    wdt_timeout_in <= 1'b0;
    sleep_req <= 1'b0;
endtask
// Pin event, bounded wait for the full reset
task hit(input bit w);
    if (w)
        wdt_timeout_in <= 1'b1;
    else
        low_voltage_in <= 1'b1;
    wt(1'b0);
    wdt_timeout_in <= 1'b0;
    low_voltage_in <= 1'b0;
endtask
initial
begin
    #5000000;
    error_cnt++;
    finish_test;
end
// ****
// Main sequence
// ****
initial
begin
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rd(4'h0, 8'h00, "ctrl");
    rd(4'h3, 8'h00, "status");
    rd(4'h1, 8'h55, "vsel");
    rd(4'h2, 8'h0A, "wden");
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00, "unmapped");
    wr(4'h0, 8'hF0);
    rd(4'h0, 8'hB0, "ctrl");
    $display("test registers done");
    wr(4'h5, 8'h08);
    nap(8'h10);
    chk("fast hold", 8'h01, {7'h0, m >= 13 && m <= 17});
    chk("irq", 8'h01, {7'h0, irq});
    rd(4'h3, 8'h03, "status");
    rd(4'h0, 8'h10, "ctrl");
    rd(4'h4, 8'h08, "irq stat");
    #1 chk("irq clr", 8'h00, {7'h0, irq});
    nap(8'h00);
    chk("slow hold", 8'h01, {7'h0, m <= 3});
    rd(4'h4, 8'h08, "irq stat");
    $display("test sleep done");
    hit(1'b0);
    rd(4'h3, 8'h03, "status");
    rd(4'h0, 8'h04, "ctrl");
    #1 chk("irq mask", 8'h00, {7'h0, irq});
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00, "ctrl");
    hit(1'b1);
    rd(4'h3, 8'h03, "status");
    $display("test events done");
    wr(4'h1, 8'h00);
    wt(1'b0);
    chk("debounce", 8'h01, {7'h0, n >= 5 && n <= 20});
    rd(4'h0, 8'h02, "ctrl");
    rd(4'h1, 8'h55, "vsel");
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h00);
    wt(1'b0);
    rd(4'h0, 8'h01, "ctrl");
    $display("test illegal codes done");
    finish_test;
end
endmodule
`default_nettype wire
